// >>> src/led_port_pkg.sv
// constants, encodings and states of the led port expander bus block
`default_nettype none
package led_port_pkg;
    localparam int PIN_COUNT = 16;
    localparam int CLK_HZ = 100_000_000;
    localparam int BLINK_BASE_HZ = 44;
    localparam int DUTY_STEPS = 256;
    // rounded down: blink periods run a hair fast
    localparam int STEP_CYCLES = CLK_HZ / (BLINK_BASE_HZ * DUTY_STEPS);
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 12;
    localparam logic [3:0] ADDR_HIGH = 4'hc;
    localparam int AUTO_STEP_BIT = 4;
    localparam logic [3:0] REG_LEVEL_A = 4'h0;
    localparam logic [3:0] REG_LEVEL_B = 4'h1;
    localparam logic [3:0] REG_PERIOD_A = 4'h2;
    localparam logic [3:0] REG_DUTY_A = 4'h3;
    localparam logic [3:0] REG_PERIOD_B = 4'h4;
    localparam logic [3:0] REG_DUTY_B = 4'h5;
    localparam logic [3:0] REG_SEL_0 = 4'h6;
    localparam logic [3:0] REG_LAST = 4'h9;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [7:0] DUTY_RESET = 8'h80;
    localparam logic [7:0] SEL_RESET = 8'h55;
    localparam logic [1:0] SEL_LOW = 2'b00;
    localparam logic [1:0] SEL_HIZ = 2'b01;
    localparam logic [1:0] SEL_WAVE_A = 2'b10;
    localparam logic [1:0] SEL_WAVE_B = 2'b11;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_RXB = 3'b011,
        ST_WACK = 3'b100,
        ST_TXB = 3'b101,
        ST_RACK = 3'b110,
        ST_WSTOP = 3'b111
    } bus_state_type;
endpackage
`default_nettype wire

// >>> src/led_port_bus.sv
// write buffer and the i2c register access and pin logic of the led port expander
`default_nettype none
module led_port_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } fifo_state_type;
    fifo_state_type r;
    fifo_state_type n;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;
    assign in_ready_out = (r.wr ^ r.rd) != {1'b1, {AW{1'b0}}};
    assign out_valid_out = r.wr != r.rd;
    assign out_data_out = mem[r.rd[AW-1:0]];
    assign push = in_valid_in && in_ready_out && ce_in;
    assign pop = out_valid_out && out_ready_in && ce_in;
    always_comb begin
        n = r;
        if (push) begin
            n.wr = r.wr + 1'b1;
        end
        if (pop) begin
            n.rd = r.rd + 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
        if (push) begin
            mem[r.wr[AW-1:0]] <= in_data_in;
        end
    end
endmodule // led_port_fifo

module led_port_bus #(
    parameter int STEP_CYCLES = led_port_pkg::STEP_CYCLES,
    parameter int FIFO_DEPTH = led_port_pkg::FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic por_ok_in,
    input wire logic ce_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [2:0] addr_pins_in,
    input wire logic [led_port_pkg::PIN_COUNT-1:0] led_in,
    output logic [led_port_pkg::PIN_COUNT-1:0] led_out,
    output logic [led_port_pkg::PIN_COUNT-1:0] led_oe_out
);
    import led_port_pkg::*;
    typedef struct packed {
        logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
        logic [2:0] adr_s1, adr_s2;
        logic [15:0] pin_s1, pin_s2;
        bus_state_type st;
        logic [3:0] bits;
        logic [7:0] shift;
        logic is_cmd, rd, acked;
        logic [3:0] ptr;
        logic auto_step_flag;
        logic sda_oe;
        logic push;
        logic [11:0] push_data;
        logic [1:0][7:0] psc, pwm, lvl, div_cnt, duty_cnt;
        logic [3:0][7:0] sel;
        logic [13:0] step_cnt;
        logic [15:0] led_oe;
    } state_type;
    state_type r;
    state_type n;
    logic in_reset;
    logic scl_rise, scl_fall, start_seen, stop_seen, step_tick;
    logic f_ready, f_valid, f_pop, drain_ok;
    logic [11:0] f_data;
    logic [1:0] wave_low;
    logic [15:0] drive_low;
    logic [31:0] sel_flat;

    function automatic logic [3:0] ptr_step(input logic [3:0] p);
        ptr_step = (p >= REG_LAST) ? 4'h0 : 4'(p + 4'h1);
    endfunction

    function automatic state_type reset_value();
        state_type v;
        v = '0;
        // synchronisers start at the idle bus level so no false edge follows reset
        {v.scl_s1, v.scl_s2, v.scl_d, v.sda_s1, v.sda_s2, v.sda_d} = 6'h3f;
        v.psc = {PERIOD_RESET, PERIOD_RESET};
        v.pwm = {DUTY_RESET, DUTY_RESET};
        v.sel = {4{SEL_RESET}};
        return v;
    endfunction

    assign in_reset = !rst_b_in || !por_ok_in;
    assign scl_rise = r.scl_s2 && !r.scl_d;
    assign scl_fall = !r.scl_s2 && r.scl_d;
    assign start_seen = r.scl_s2 && r.scl_d && r.sda_d && !r.sda_s2;
    assign stop_seen = r.scl_s2 && r.scl_d && !r.sda_d && r.sda_s2;
    assign step_tick = r.step_cnt == 14'(STEP_CYCLES - 1);
    // the drain pauses during the master acknowledge slot so a read load sees settled registers
    assign drain_ok = r.st != ST_RACK;
    assign f_pop = f_valid && drain_ok && ce_in;
    assign sel_flat = r.sel;
    assign sda_out = 1'b0;
    assign sda_oe_out = r.sda_oe;
    assign led_out = '0;
    assign led_oe_out = r.led_oe;

    led_port_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .rst_b_in(!in_reset),
        .ce_in(ce_in),
        .in_valid_in(r.push),
        .in_data_in(r.push_data),
        .in_ready_out(f_ready),
        .out_valid_out(f_valid),
        .out_data_out(f_data),
        .out_ready_in(drain_ok)
    );

    for (genvar c = 0; c < 2; c++) begin : g_wave
        assign wave_low[c] = r.duty_cnt[c] < r.pwm[c];
    end
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        logic [1:0] code;
        assign code = sel_flat[2*i +: 2];
        assign drive_low[i] = (code == SEL_LOW)
            || (code == SEL_WAVE_A && wave_low[0])
            || (code == SEL_WAVE_B && wave_low[1]);
    end

    always_comb begin
        logic [7:0] tx;
        tx = 8'h00;
        n = r;
        n.push = 1'b0;
        n.scl_s1 = scl_in;
        n.scl_s2 = r.scl_s1;
        n.scl_d = r.scl_s2;
        n.sda_s1 = sda_in;
        n.sda_s2 = r.sda_s1;
        n.sda_d = r.sda_s2;
        n.adr_s1 = addr_pins_in;
        n.adr_s2 = r.adr_s1;
        n.pin_s1 = led_in;
        n.pin_s2 = r.pin_s1;
        n.led_oe = drive_low;
        n.step_cnt = step_tick ? 14'h0 : 14'(r.step_cnt + 14'h1);
        for (int c = 0; c < 2; c++) begin
            if (step_tick) begin
                if (r.div_cnt[c] == r.psc[c]) begin
                    n.div_cnt[c] = 8'h00;
                    n.duty_cnt[c] = 8'(r.duty_cnt[c] + 8'h01);
                end else begin
                    n.div_cnt[c] = 8'(r.div_cnt[c] + 8'h01);
                end
            end
        end
        if (f_pop) begin
            unique case (f_data[11:8])
                REG_PERIOD_A: n.psc[0] = f_data[7:0];
                REG_PERIOD_B: n.psc[1] = f_data[7:0];
                REG_DUTY_A, REG_DUTY_B: begin
                    n.pwm[f_data[10]] = f_data[7:0];
                    n.duty_cnt[f_data[10]] = 8'h00;
                    n.div_cnt[f_data[10]] = 8'h00;
                end
                4'h6, 4'h7, 4'h8, 4'h9: n.sel[2'(f_data[11:8] - REG_SEL_0)] = f_data[7:0];
                default: ;
            endcase
        end
        unique case (r.ptr)
            REG_LEVEL_A: tx = r.pin_s2[7:0];
            REG_LEVEL_B: tx = r.pin_s2[15:8];
            REG_PERIOD_A: tx = r.psc[0];
            REG_DUTY_A: tx = r.pwm[0];
            REG_PERIOD_B: tx = r.psc[1];
            REG_DUTY_B: tx = r.pwm[1];
            4'h6, 4'h7, 4'h8, 4'h9: tx = r.sel[2'(r.ptr - REG_SEL_0)];
            default: tx = 8'h00;
        endcase
        if (start_seen) begin
            n.st = ST_ADDR;
            n.bits = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop_seen) begin
            n.st = ST_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            unique case (r.st)
                ST_IDLE, ST_WSTOP: ;
                ST_ADDR, ST_RXB: begin
                    if (scl_rise) begin
                        n.shift = {r.shift[6:0], r.sda_s2};
                        n.bits = 4'(r.bits + 4'h1);
                    end else if (scl_fall && r.bits == 4'h8) begin
                        n.st = ST_WACK;
                        n.sda_oe = 1'b1;
                        if (r.st == ST_ADDR) begin
                            n.rd = r.shift[0];
                            n.is_cmd = !r.shift[0];
                            if (r.shift[7:1] == {ADDR_HIGH, r.adr_s2}) begin
                                n.st = ST_AACK;
                            end else begin
                                n.st = ST_WSTOP;
                                n.sda_oe = 1'b0;
                            end
                        end else if (r.is_cmd) begin
                            n.ptr = r.shift[3:0];
                            n.auto_step_flag = r.shift[AUTO_STEP_BIT];
                            n.is_cmd = 1'b0;
                        end else if (f_ready) begin
                            n.push = 1'b1;
                            n.push_data = {r.ptr, r.shift};
                            if (r.auto_step_flag) begin
                                n.ptr = ptr_step(r.ptr);
                            end
                        end else begin
                            // full buffer: refuse the byte rather than lose it
                            n.st = ST_WSTOP;
                            n.sda_oe = 1'b0;
                        end
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.st = ST_RXB;
                        n.bits = 4'h0;
                    end
                end
                ST_AACK, ST_RACK: begin
                    if (scl_rise && r.st == ST_RACK) begin
                        n.acked = !r.sda_s2;
                    end else if (scl_fall && !r.rd) begin
                        n.sda_oe = 1'b0;
                        n.st = ST_RXB;
                        n.bits = 4'h0;
                    end else if (scl_fall && (r.st == ST_AACK || r.acked)) begin
                        n.lvl = {r.pin_s2[15:8], r.pin_s2[7:0]};
                        n.shift = tx;
                        n.sda_oe = !tx[7];
                        n.bits = 4'h0;
                        n.st = ST_TXB;
                        if (r.auto_step_flag) begin
                            n.ptr = ptr_step(r.ptr);
                        end
                    end else if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.st = ST_WSTOP;
                    end
                end
                ST_TXB: begin
                    if (scl_fall) begin
                        if (r.bits == 4'h7) begin
                            n.sda_oe = 1'b0;
                            n.acked = 1'b0;
                            n.st = ST_RACK;
                        end else begin
                            n.shift = {r.shift[6:0], 1'b0};
                            n.sda_oe = !r.shift[6];
                            n.bits = 4'(r.bits + 4'h1);
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (in_reset) begin
            r <= reset_value();
        end else if (ce_in) begin
            r <= n;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (in_reset);
    sequence seq_load;
        ce_in && scl_fall && !start_seen && !stop_seen && r.rd
            && (r.st == ST_AACK || (r.st == ST_RACK && r.acked));
    endsequence
    sequence seq_pop_period_a;
        f_pop && f_data[11:8] == REG_PERIOD_A;
    endsequence

    chk_pin_drive_low: assert property (ce_in && r.sel[0][1:0] == SEL_LOW |=> led_oe_out[0])
        else $error("pin 0 not driven low");
    chk_pin_release: assert property (ce_in && r.sel[3][7:6] == SEL_HIZ |=> !led_oe_out[15])
        else $error("pin 15 not released");
    chk_wave_a_out: assert property (ce_in && r.sel[0][1:0] == SEL_WAVE_A
        |=> led_oe_out[0] == ($past(r.duty_cnt[0]) < $past(r.pwm[0])))
        else $error("pin 0 does not follow wave a");
    chk_reg_default: assert property (disable iff (1'b0) !rst_b_in
        |=> r.psc[0] == PERIOD_RESET && r.pwm[1] == DUTY_RESET && r.st == ST_IDLE)
        else $error("registers not at default in reset");
    chk_por_hold: assert property (disable iff (1'b0) !por_ok_in
        |=> r.sel == {4{SEL_RESET}} && !sda_oe_out)
        else $error("power-on reset not held");
    chk_write_store: assert property (seq_pop_period_a |=> r.psc[0] == $past(f_data[7:0]))
        else $error("written byte not stored");
    chk_level_ro: assert property (f_pop && f_data[11:8] <= REG_LEVEL_B
        |=> r.psc == $past(r.psc) && r.sel == $past(r.sel) && r.pwm == $past(r.pwm))
        else $error("level register write changed state");
    chk_read_load: assert property (seq_load and r.ptr == REG_PERIOD_A
        |=> r.shift == $past(r.psc[0]) && r.st == ST_TXB ##1 sda_oe_out == !r.shift[7])
        else $error("read byte not loaded");
    chk_level_capture: assert property (seq_load |=> r.lvl == $past(r.pin_s2))
        else $error("pin levels not captured");
    chk_ptr_wrap: assert property (seq_load and r.auto_step_flag && r.ptr == REG_LAST
        |=> r.ptr == 4'h0)
        else $error("pointer did not wrap");
endmodule // led_port_bus
`default_nettype wire

// >>> sim/i2c_master_model.sv
// behavioural i2c bus master driving the expander's serial pins
`default_nettype none
module i2c_master_model (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_pull_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // also a repeated start; 8 clk phases stay above the 4 clk minimum
    task automatic start_cond();
        sda_pull_out <= 1'b0;
        tick(4);
        scl_out <= 1'b1;
        tick(8);
        sda_pull_out <= 1'b1;
        tick(8);
        scl_out <= 1'b0;
        tick(4);
    endtask
    task automatic stop_cond();
        sda_pull_out <= 1'b1;
        tick(4);
        scl_out <= 1'b1;
        tick(8);
        sda_pull_out <= 1'b0;
        tick(8);
    endtask
    task automatic bit_out(input logic b);
        sda_pull_out <= !b;
        tick(4);
        scl_out <= 1'b1;
        tick(8);
        scl_out <= 1'b0;
        tick(4);
    endtask
    // released line reads the pull-up unless the device pulls it
    task automatic bit_in(output logic b);
        sda_pull_out <= 1'b0;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        b = sda_in;
        tick(4);
        scl_out <= 1'b0;
        tick(4);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(a);
        ack = !a;
    endtask
    // the last byte gets no acknowledge; the caller then stops
    task automatic rd_byte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(last);
    endtask
endmodule // i2c_master_model
`default_nettype wire

// >>> sim/led_port_bus_tb.sv
// self-checking bench for the led port expander bus block
`default_nettype none
module led_port_bus_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import led_port_pkg::*;
    typedef struct packed {
        logic [3:0] ptr;
        logic [7:0] val;
        logic [15:0] oe;
    } row_type;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic por_ok_in = 1'b1;
    logic [15:0] ext_low = 16'h0000;
    logic scl, m_pull, sda_oe, sda_wire;
    logic [15:0] led_oe, led_lvl, cnt_a, cnt_b, led_o;
    logic ce = 1'b1;
    logic [2:0] adr = 3'b000;
    // address byte with the direction bit clear; must follow adr
    logic [7:0] dev = 8'hc0;
    logic sda_o, ack;
    logic [7:0] rd_buf [8];
    int miscompares = 0;
    int compares = 0;
    row_type rows [7] = '{'{4'h6, 8'h00, 16'h000f}, '{4'h7, 8'h00, 16'h00ff},
        '{4'h6, 8'h55, 16'h00f0}, '{4'h9, 8'h54, 16'h10f0}, '{4'h8, 8'h45, 16'h14f0},
        '{4'h7, 8'h55, 16'h1400}, '{4'h9, 8'h55, 16'h0400}};
    always #5 clk_in = ~clk_in;
    // open drain wires with external pull-ups
    assign sda_wire = !(m_pull | (sda_oe & !sda_o));
    assign led_lvl = ~((led_oe & ~led_o) | ext_low);
    i2c_master_model i_m (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl),
        .sda_pull_out(m_pull));
    led_port_bus #(.STEP_CYCLES(4), .FIFO_DEPTH(32)) i_led_port_bus (.clk_in(clk_in),
        .rst_b_in(rst_b_in), .por_ok_in(por_ok_in), .ce_in(ce), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_pins_in(adr),
        .led_in(led_lvl), .led_out(led_o), .led_oe_out(led_oe));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] d);
        logic a;
        i_m.wr_byte(d, a);
        chk8({7'h0, a}, 8'h01);
    endtask
    // first data byte sits in the top byte of d
    task automatic wr(input logic [7:0] cmd, input logic [39:0] d, input int cnt);
        i_m.start_cond();
        send(dev);
        send(cmd);
        for (int i = 0; i < cnt; i++) begin
            send(d[39-8*i -: 8]);
        end
        i_m.stop_cond();
    endtask
    task automatic rd(input logic [7:0] cmd, input int cnt);
        i_m.start_cond();
        send(dev);
        send(cmd);
        i_m.start_cond();
        send(dev | 8'h01);
        for (int i = 0; i < cnt; i++) begin
            i_m.rd_byte(rd_buf[i], i == cnt - 1);
        end
        i_m.stop_cond();
    endtask
    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_in);
        miscompares++;
        $display("wrong value at %0t: run timed out", $time);
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rd(8'h12, 8);
        for (int i = 2; i < 10; i++) begin
            chk8(rd_buf[i-2], i < 6 ? (i[0] ? DUTY_RESET : PERIOD_RESET) : SEL_RESET);
        end
        $display("test defaults done");
        foreach (rows[i]) begin
            wr({4'h0, rows[i].ptr}, {rows[i].val, 32'h0}, 1);
            rd({4'h0, rows[i].ptr}, 1);
            chk8(rd_buf[0], rows[i].val);
            chk16(led_oe, rows[i].oe);
        end
        $display("test rows done");
        // ignored top bits, wrap past the last register, level registers untouched
        ext_low <= 16'ha53c;
        wr(8'hf8, 40'h55_55_aa_aa_07, 5);
        rd(8'h18, 5);
        chk8(rd_buf[1], 8'h55);
        chk8(rd_buf[2], 8'hc3);
        chk8(rd_buf[3], 8'h5a);
        chk8(rd_buf[4], 8'h07);
        $display("test wrap done");
        wr(8'h12, 40'h00_80_00_00_5e, 5);
        cnt_a = 16'h0;
        cnt_b = 16'h0;
        repeat (2048) begin
            @(negedge clk_in);
            cnt_a = cnt_a + led_oe[0];
            cnt_b = cnt_b + led_oe[1];
        end
        chk16(cnt_a, 16'd1024);
        chk16(cnt_b, 16'd0);
        $display("test blink done");
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        repeat (3) @(negedge clk_in);
        chk16(led_oe, 16'h0);
        @(posedge clk_in);
        rst_b_in <= 1'b1;
        rd(8'h06, 1);
        chk8(rd_buf[0], SEL_RESET);
        wr(8'h06, 40'h0, 1);
        chk16(led_oe, 16'h000f);
        por_ok_in <= 1'b0;
        repeat (3) @(negedge clk_in);
        chk16(led_oe, 16'h0);
        @(posedge clk_in);
        por_ok_in <= 1'b1;
        rd(8'h02, 1);
        chk8(rd_buf[0], PERIOD_RESET);
        $display("test resets done");
        // a frozen block answers nothing, so its own address goes unacknowledged
        ce <= 1'b0;
        i_m.start_cond();
        i_m.wr_byte(8'hc0, ack);
        chk8({7'h0, ack}, 8'h00);
        i_m.stop_cond();
        ce <= 1'b1;
        rd(8'h02, 1);
        chk8(rd_buf[0], PERIOD_RESET);
        // moved address straps: the old address is refused, the new one answers
        adr <= 3'b101;
        dev = 8'hca;
        i_m.start_cond();
        i_m.wr_byte(8'hc0, ack);
        chk8({7'h0, ack}, 8'h00);
        i_m.stop_cond();
        wr(8'h06, 40'h50_00_00_00_00, 1);
        rd(8'h06, 1);
        chk8(rd_buf[0], 8'h50);
        chk16(led_oe, 16'h0003);
        chk16(led_o, 16'h0000);
        chk8({7'h0, sda_o}, 8'h00);
        $display("test enable and address done");
        give_verdict();
    end
endmodule // led_port_bus_tb
`default_nettype wire
